/* rom_ctrl.sv */
// operating mode state machine of the radio
`timescale 1ns/1ps
`include "rom_consts.svh"
module rom_ctrl
#(
  parameter int STARTUP_CYC = `ROM_STARTUP_CYC,
  parameter int LOCK_TO_CYC = `ROM_LOCK_TO_CYC,
  parameter int PROTO_TO_CYC = `ROM_PROTO_TO_CYC
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // power pin and analog status
  input wire logic power_off_pin_in,
  input wire logic lock_detect_in,
  // serial pins
  input wire logic sclk_in,
  input wire logic csn_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // radio events
  input wire logic tx_done_in,
  input wire logic tx_underflow_in,
  input wire logic rx_done_in,
  input wire logic rx_timeout_in,
  input wire logic rx_overflow_in,
  input wire logic auto_turn_in,
  input wire logic protocol_done_in,
  input wire logic wake_in,
  // configuration
  input wire logic direct_mode_in,
  input wire logic persist_tx_in,
  input wire logic persist_rx_in,
  input wire logic protocol_en_in,
  input wire logic low_duty_cycle_receive_in,
  // status
  output rom_pkg::rom_state_t state_out,
  output logic [6:0] state_code_out,
  output logic supply_on_out,
  output logic crystal_oscillator_on_out,
  output logic synth_on_out,
  output logic gpio_ready_out,
  output logic gpio_ready_oe_out
);
  import rom_pkg::*;
  localparam int CW = `ROM_CNT_W;
  localparam int TURN_CYC = `ROM_TURN_CYC;

  if (STARTUP_CYC < 1 || STARTUP_CYC >= 2 ** CW ||
      LOCK_TO_CYC < 1 || LOCK_TO_CYC >= 2 ** CW ||
      PROTO_TO_CYC < 1 || PROTO_TO_CYC >= 2 ** CW)
  begin : g_bad_param
    $error("timeout parameter out of counter range");
  end

  rom_state_t st;
  rom_state_t next_st;
  logic [1:0] off_s;
  logic [1:0] lock_s;
  logic off;
  logic lock_det;
  logic [CW-1:0] cnt;
  logic lock_hold;
  logic lock_to_tx;
  logic turn;
  logic pend_rx;
  logic next_hold;
  logic next_to_tx;
  logic next_turn;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic tx_end;
  logic rx_end;
  logic lock_reached;
  rom_state_t tx_dest;
  rom_state_t rx_dest;

  rom_spi_cmd u_spi
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(st != ROM_SHUTDOWN),
    .status_in(state_code_out),
    .sclk_in(sclk_in),
    .csn_in(csn_in),
    .mosi_in(mosi_in),
    .miso_out(miso_out),
    .miso_oe_out(miso_oe_out),
    .cmd_valid_out(cmd_valid),
    .cmd_code_out(cmd_code)
  );

  // pin and analog levels cross into the clock domain
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      off_s <= 2'h0;
      lock_s <= 2'h0;
    end
    else
    begin
      off_s <= {off_s[0], power_off_pin_in};
      lock_s <= {lock_s[0], lock_detect_in};
    end
  end

  assign off = off_s[1];
  assign lock_det = lock_s[1];

  // abort shares the completion destinations, so persistence still wins
  assign tx_end = tx_done_in | (direct_mode_in & tx_underflow_in) |
                  (cmd_valid & cmd_code == `ROM_CMD_ABORT);
  assign rx_end = rx_done_in | rx_timeout_in |
                  (direct_mode_in & rx_overflow_in) |
                  (cmd_valid & cmd_code == `ROM_CMD_ABORT);
  assign tx_dest = persist_tx_in ? ROM_TX :
                   protocol_en_in ? ROM_PROTO : ROM_READY;
  assign rx_dest = persist_rx_in ? ROM_RX :
                   protocol_en_in ? ROM_PROTO :
                   low_duty_cycle_receive_in ? ROM_SLEEP :
                   ROM_READY;
  assign lock_reached = lock_det ||
    (turn ? cnt >= CW'(TURN_CYC - 1)
          : cnt >= CW'(LOCK_TO_CYC - 1));

  always_comb
  begin
    next_st = st;
    next_hold = lock_hold;
    next_to_tx = lock_to_tx;
    next_turn = turn;
    case (st)
      ROM_SHUTDOWN:
        next_st = ROM_STARTUP;
      ROM_STARTUP:
        if (cnt == CW'(STARTUP_CYC - 1))
          next_st = ROM_READY;
      ROM_READY:
        if (cmd_valid)
        begin
          // transmit and receive lock first and pass on unattended
          if (cmd_code == `ROM_CMD_TX || cmd_code == `ROM_CMD_RX)
          begin
            next_st = ROM_LOCK;
            next_hold = 1'b0;
            next_to_tx = (cmd_code == `ROM_CMD_TX);
            next_turn = 1'b0;
          end
          else if (cmd_code == `ROM_CMD_LOCK_RX ||
                   cmd_code == `ROM_CMD_LOCK_TX)
          begin
            next_st = ROM_LOCK;
            next_hold = 1'b1;
            next_to_tx = (cmd_code == `ROM_CMD_LOCK_TX);
            next_turn = 1'b0;
          end
          else if (cmd_code == `ROM_CMD_STANDBY)
            next_st = ROM_STANDBY;
          else if (cmd_code == `ROM_CMD_SLEEP)
            next_st = ROM_SLEEP;
        end
      ROM_STANDBY:
        if (cmd_valid && cmd_code == `ROM_CMD_READY)
          next_st = ROM_READY;
      ROM_SLEEP:
        if (cmd_valid && cmd_code == `ROM_CMD_READY)
          next_st = ROM_READY;
        else if (wake_in && pend_rx)
        begin
          next_st = ROM_LOCK;
          next_hold = 1'b0;
          next_to_tx = 1'b0;
          next_turn = 1'b0;
        end
      ROM_LOCK:
        if (lock_hold)
        begin
          if (cmd_valid && cmd_code == `ROM_CMD_READY)
            next_st = ROM_READY;
        end
        else if (lock_reached)
          next_st = lock_to_tx ? ROM_TX : ROM_RX;
      ROM_RX:
        if (rx_end)
          next_st = rx_dest;
        else if (auto_turn_in)
        begin
          next_st = ROM_LOCK;
          next_hold = 1'b0;
          next_to_tx = 1'b1;
          next_turn = 1'b1;
        end
      ROM_TX:
        if (tx_end)
          next_st = tx_dest;
        else if (auto_turn_in)
        begin
          next_st = ROM_LOCK;
          next_hold = 1'b0;
          next_to_tx = 1'b0;
          next_turn = 1'b1;
        end
      ROM_PROTO:
        if (protocol_done_in || cnt == CW'(PROTO_TO_CYC - 1))
          next_st = ROM_READY;
      default:
        next_st = ROM_READY;
    endcase
    // other commands fall through the case untouched
    if (off)
      next_st = ROM_SHUTDOWN;
  end

  // power-on reset lands directly in ready with the crystal running
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      st <= ROM_READY;
      cnt <= '0;
      lock_hold <= 1'b0;
      lock_to_tx <= 1'b0;
      turn <= 1'b0;
    end
    else
    begin
      st <= next_st;
      cnt <= (next_st != st) ? '0 : cnt + CW'(1);
      lock_hold <= next_hold;
      lock_to_tx <= next_to_tx;
      turn <= next_turn;
    end
  end

  // pending receive survives sleep; shutdown loses it with everything
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      pend_rx <= 1'b0;
    else if (next_st == ROM_SHUTDOWN)
      pend_rx <= 1'b0;
    else if (st == ROM_RX && next_st == ROM_SLEEP)
      pend_rx <= 1'b1;
    else if (st == ROM_SLEEP && next_st != ROM_SLEEP)
      pend_rx <= 1'b0;
  end

  // status follows the state one clock later
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_out <= ROM_READY;
      state_code_out <= `ROM_CODE_READY;
      supply_on_out <= 1'b1;
      crystal_oscillator_on_out <= 1'b1;
      synth_on_out <= 1'b0;
      gpio_ready_out <= 1'b1;
      gpio_ready_oe_out <= 1'b1;
    end
    else
    begin
      state_out <= st;
      case (st)
        ROM_STANDBY: state_code_out <= `ROM_CODE_STANDBY;
        ROM_SLEEP: state_code_out <= `ROM_CODE_SLEEP;
        ROM_READY: state_code_out <= `ROM_CODE_READY;
        ROM_LOCK: state_code_out <= `ROM_CODE_LOCK;
        ROM_RX: state_code_out <= `ROM_CODE_RX;
        ROM_TX: state_code_out <= `ROM_CODE_TX;
        ROM_PROTO: state_code_out <= `ROM_CODE_PROTO;
        default: state_code_out <= `ROM_CODE_OFF;
      endcase
      supply_on_out <= (st != ROM_SHUTDOWN);
      crystal_oscillator_on_out <= !(st == ROM_SHUTDOWN ||
        st == ROM_STANDBY || st == ROM_SLEEP);
      synth_on_out <= (st == ROM_LOCK || st == ROM_RX ||
                       st == ROM_TX);
      gpio_ready_out <= (st == ROM_READY);
      gpio_ready_oe_out <= (st != ROM_SHUTDOWN);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_shutdown_hiz;
    (st == ROM_SHUTDOWN) |=> (!miso_oe_out && !gpio_ready_oe_out &&
      !supply_on_out);
  endproperty
  a_shutdown_hiz: assert property (p_shutdown_hiz)
    else $error("pins driven during shutdown");

  property p_release;
    (st == ROM_SHUTDOWN && !off) |=> (st == ROM_STARTUP);
  endproperty
  a_release: assert property (p_release)
    else $error("shutdown release did not start up");

  property p_startup;
    (st == ROM_STARTUP && cnt == CW'(STARTUP_CYC - 1) && !off)
      |=> (st == ROM_READY) ##1 (state_code_out == `ROM_CODE_READY);
  endproperty
  a_startup: assert property (p_startup)
    else $error("startup did not end in ready on time");

  property p_no_direct;
    ((st == ROM_RX) |=> (st != ROM_TX)) and
    ((st == ROM_TX) |=> (st != ROM_RX));
  endproperty
  a_no_direct: assert property (p_no_direct)
    else $error("direct switch between receive and transmit");

  property p_stable;
    (st inside {ROM_READY, ROM_STANDBY} && !cmd_valid && !off)
      |=> (st == $past(st));
  endproperty
  a_stable: assert property (p_stable)
    else $error("stable state left without command");

  property p_codes;
    ((st == ROM_TX) |=> (state_code_out == `ROM_CODE_TX)) and
    ((st == ROM_STANDBY) |=> (state_code_out == `ROM_CODE_STANDBY));
  endproperty
  a_codes: assert property (p_codes)
    else $error("state code mismatch");

  property p_lock_to;
    (st == ROM_LOCK && !lock_hold && !turn &&
     cnt == CW'(LOCK_TO_CYC - 1) && !off) |=> (st != ROM_LOCK);
  endproperty
  a_lock_to: assert property (p_lock_to)
    else $error("lock timeout ignored");

  property p_low_duty_cycle_receive;
    (st == ROM_RX && rx_end && !persist_rx_in && !protocol_en_in &&
     low_duty_cycle_receive_in && !off) |=> (st == ROM_SLEEP && pend_rx);
  endproperty
  a_low_duty_cycle_receive: assert property (p_low_duty_cycle_receive)
    else $error("receive completion did not sleep");

  property p_ignored;
    (st == ROM_STANDBY && cmd_valid && cmd_code == `ROM_CMD_TX && !off)
      |=> (st == ROM_STANDBY);
  endproperty
  a_ignored: assert property (p_ignored)
    else $error("disallowed command changed state");

  c_tx: cover property (st == ROM_LOCK ##1 st == ROM_TX);
  c_wake: cover property (st == ROM_SLEEP ##1 st == ROM_LOCK);
  c_turn: cover property (st == ROM_RX && auto_turn_in && !rx_end);
  c_abort: cover property (st == ROM_TX && cmd_valid &&
                           cmd_code == `ROM_CMD_ABORT);
endmodule

/* rom_consts.svh */
// constants of the radio operating mode controller
`ifndef ROM_CONSTS_SVH
`define ROM_CONSTS_SVH
`define ROM_CLK_MHZ 250
`define ROM_STARTUP_US 650
`define ROM_STARTUP_CYC (`ROM_STARTUP_US * `ROM_CLK_MHZ)
`define ROM_TURN_US 15
`define ROM_TURN_CYC (`ROM_TURN_US * `ROM_CLK_MHZ)
`define ROM_LOCK_TO_US 80
`define ROM_LOCK_TO_CYC (`ROM_LOCK_TO_US * `ROM_CLK_MHZ)
`define ROM_PROTO_TO_US 1000
`define ROM_PROTO_TO_CYC (`ROM_PROTO_TO_US * `ROM_CLK_MHZ)
`define ROM_CNT_W 24
`define ROM_CMD_HEADER 8'h80
`define ROM_CMD_TX 8'h60
`define ROM_CMD_RX 8'h61
`define ROM_CMD_READY 8'h62
`define ROM_CMD_STANDBY 8'h63
`define ROM_CMD_SLEEP 8'h64
`define ROM_CMD_LOCK_RX 8'h65
`define ROM_CMD_LOCK_TX 8'h66
`define ROM_CMD_ABORT 8'h67
`define ROM_CODE_OFF 7'h00
`define ROM_CODE_STANDBY 7'h40
`define ROM_CODE_SLEEP 7'h36
`define ROM_CODE_READY 7'h03
`define ROM_CODE_LOCK 7'h0F
`define ROM_CODE_RX 7'h33
`define ROM_CODE_TX 7'h5F
`define ROM_CODE_PROTO 7'h1F
`endif

/* rom_pkg.sv */
// types of the radio operating mode controller
package rom_pkg;
  typedef enum logic [3:0] {
    ROM_SHUTDOWN = 4'h0,
    ROM_STARTUP = 4'h1,
    ROM_READY = 4'h2,
    ROM_STANDBY = 4'h3,
    ROM_SLEEP = 4'h4,
    ROM_LOCK = 4'h5,
    ROM_RX = 4'h6,
    ROM_TX = 4'h7,
    ROM_PROTO = 4'h8
  } rom_state_t;
endpackage

/* rom_spi_cmd.sv */
// serial command receiver sampled on the system clock
`timescale 1ns/1ps
`include "rom_consts.svh"
module rom_spi_cmd
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // control
  input wire logic enable_in,
  input wire logic [6:0] status_in,
  // serial pins
  input wire logic sclk_in,
  input wire logic csn_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // decoded command
  output logic cmd_valid_out,
  output logic [7:0] cmd_code_out
);
  import rom_pkg::*;
  logic [2:0] sclk_s;
  logic [1:0] csn_s;
  logic [1:0] mosi_s;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [2:0] bitcnt;
  logic first;
  logic hdr_ok;
  logic rise;
  logic fall;
  logic idle;
  logic [7:0] byte_in;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sclk_s <= 3'h0;
      csn_s <= 2'h3;
      mosi_s <= 2'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], sclk_in};
      csn_s <= {csn_s[0], csn_in};
      mosi_s <= {mosi_s[0], mosi_in};
    end
  end

  assign rise = sclk_s[1] & ~sclk_s[2];
  assign fall = ~sclk_s[1] & sclk_s[2];
  assign idle = csn_s[1] | ~enable_in;
  assign byte_in = {shreg[6:0], mosi_s[1]};

  // byte framing; after a command the next byte is a fresh header, so
  // further accesses may follow without lifting chip select
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      first <= 1'b1;
      hdr_ok <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_code_out <= 8'h00;
    end
    else
    begin
      cmd_valid_out <= 1'b0;
      if (idle)
      begin
        bitcnt <= 3'h0;
        first <= 1'b1;
        hdr_ok <= 1'b0;
      end
      else if (rise)
      begin
        shreg <= byte_in;
        bitcnt <= bitcnt + 3'h1;
        if (bitcnt == 3'h7)
        begin
          if (first)
          begin
            hdr_ok <= (byte_in == `ROM_CMD_HEADER);
            first <= 1'b0;
          end
          else
          begin
            cmd_valid_out <= hdr_ok;
            if (hdr_ok)
              cmd_code_out <= byte_in;
            first <= hdr_ok;
            hdr_ok <= 1'b0;
          end
        end
      end
    end
  end

  // status byte goes out during each header byte
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      txreg <= 8'h00;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end
    else
    begin
      miso_oe_out <= ~idle;
      // the msb must stand before the first rise, so it is shown at load
      // and each later fall moves on to the next bit
      if (idle || (rise && bitcnt == 3'h7))
      begin
        txreg <= {1'b0, status_in};
        miso_out <= 1'b0;
      end
      else if (fall && first && bitcnt != 3'h0)
      begin
        miso_out <= txreg[6];
        txreg <= {txreg[6:0], 1'b0};
      end
    end
  end
endmodule

/* rom_host_model.sv */
// serial command host model driving the mode controller pins
`timescale 1ns/1ps
module rom_host_model
(
  // serial pins
  output logic sclk_out,
  output logic csn_out,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic miso_oe_in
);
  localparam realtime HALF = 62.5;
  // miso bits gathered as each byte goes out; the header's are status
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] status_seen = 8'h00;
  initial
  begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    mosi_out = 1'b0;
  end
  // mode 0: data changes while sclk is low, the clock idles low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_out = b[i];
      #(HALF);
      rx_byte = {rx_byte[6:0], miso_in};
      sclk_out = 1'b1;
      #(HALF);
      sclk_out = 1'b0;
    end
  endtask
  // one or two commands under a single select
  task automatic send_frame(input logic [7:0] c0, input logic [7:0] c1,
    input bit two);
    csn_out = 1'b0;
    #(HALF);
    send_byte(8'h80);
    status_seen = rx_byte;
    send_byte(c0);
    if (two)
    begin
      send_byte(8'h80);
      send_byte(c1);
    end
    #(HALF);
    csn_out = 1'b1;
    // a released line must not keep showing the last bit
    mosi_out = ~mosi_out;
  endtask
endmodule

/* tb.sv */
// self-checking bench of the radio operating mode controller
`timescale 1ns/1ps
`include "rom_consts.svh"
module tb;
  import rom_pkg::*;
  localparam int SU = 50;
  localparam int LT = 40;
  localparam int PT = 60;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic power_off = 1'b0;
  logic lock_det = 1'b0;
  logic sclk, csn, mosi, miso, miso_oe;
  // 0 tx done, 1 underflow, 2 rx done, 3 timeout, 4 overflow, 5 turn,
  // 6 protocol done, 7 wake
  logic [7:0] evt = 8'h00;
  // 0 direct, 1 persist tx, 2 persist rx, 3 protocol, 4 low duty
  logic [4:0] cfg = 5'h00;
  rom_state_t st;
  logic [6:0] code;
  logic supply, xo, synth, gpio_rdy, gpio_oe;
  int n_mismatch = 0;
  int cmp_count = 0;
  int waited;
  always #2 clk_in = ~clk_in;
  rom_host_model rom_host_model_inst (.sclk_out(sclk), .csn_out(csn),
    .mosi_out(mosi), .miso_in(miso), .miso_oe_in(miso_oe));
  rom_ctrl #(.STARTUP_CYC(SU), .LOCK_TO_CYC(LT), .PROTO_TO_CYC(PT))
  rom_ctrl_inst (.clk_in(clk_in), .reset_in(reset_in),
    .power_off_pin_in(power_off), .lock_detect_in(lock_det),
    .sclk_in(sclk), .csn_in(csn), .mosi_in(mosi), .miso_out(miso),
    .miso_oe_out(miso_oe), .tx_done_in(evt[0]), .tx_underflow_in(evt[1]),
    .rx_done_in(evt[2]), .rx_timeout_in(evt[3]), .rx_overflow_in(evt[4]),
    .auto_turn_in(evt[5]), .protocol_done_in(evt[6]), .wake_in(evt[7]),
    .direct_mode_in(cfg[0]), .persist_tx_in(cfg[1]),
    .persist_rx_in(cfg[2]), .protocol_en_in(cfg[3]),
    .low_duty_cycle_receive_in(cfg[4]), .state_out(st),
    .state_code_out(code), .supply_on_out(supply),
    .crystal_oscillator_on_out(xo), .synth_on_out(synth),
    .gpio_ready_out(gpio_rdy), .gpio_ready_oe_out(gpio_oe));
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      n_mismatch++;
    end
  endtask
  task automatic hold(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  // bounded wait until the code matches (eq) or differs (!eq)
  task automatic wait_code(input logic [6:0] exp, input int bound,
    input bit eq);
    for (waited = 0; waited < bound; waited++)
    begin
      @(posedge clk_in);
      #1;
      if ((code === exp) == eq)
        return;
    end
    $display("unexpected at %0t: no state code %h", $time, exp);
    n_mismatch++;
    print_verdict();
  endtask
  task automatic pulse(input int i);
    @(posedge clk_in);
    #1 evt[i] = 1'b1;
    @(posedge clk_in);
    #1 evt[i] = 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    rom_host_model_inst.send_frame(c, 8'h00, 1'b0);
  endtask
  task automatic s_reset();
    check(code, `ROM_CODE_READY);
    check({3'h0, st}, {3'h0, ROM_READY});
    check({6'h00, gpio_rdy}, 7'h01);
    check({6'h00, synth}, 7'h00);
    check({6'h00, miso_oe}, 7'h00);
  endtask
  task automatic s_lock();
    lock_det = 1'b1;
    cmd(`ROM_CMD_LOCK_TX);
    wait_code(`ROM_CODE_LOCK, 40, 1'b1);
    check({6'h00, synth}, 7'h01);
    hold(LT + 20);
    check(code, `ROM_CODE_LOCK);
    cmd(`ROM_CMD_READY);
    wait_code(`ROM_CODE_READY, 40, 1'b1);
  endtask
  task automatic s_tx();
    lock_det = 1'b0;
    cfg[1] = 1'b1;
    cmd(`ROM_CMD_TX);
    wait_code(`ROM_CODE_LOCK, 40, 1'b1);
    wait_code(`ROM_CODE_TX, LT + 20, 1'b1);
    cmd(`ROM_CMD_RX);
    hold(30);
    check(code, `ROM_CODE_TX);
    pulse(0);
    hold(10);
    check(code, `ROM_CODE_TX);
    cfg[1] = 1'b0;
    pulse(0);
    wait_code(`ROM_CODE_READY, 20, 1'b1);
  endtask
  task automatic s_rx();
    lock_det = 1'b1;
    cfg[4] = 1'b1;
    // receive from ready, then abort, under one select
    rom_host_model_inst.send_frame(`ROM_CMD_RX, `ROM_CMD_ABORT,
      1'b1);
    wait_code(`ROM_CODE_SLEEP, 40, 1'b1);
    pulse(7);
    wait_code(`ROM_CODE_LOCK, 20, 1'b1);
    wait_code(`ROM_CODE_RX, 40, 1'b1);
    cfg[4] = 1'b0;
    pulse(5);
    wait_code(`ROM_CODE_LOCK, 20, 1'b1);
    wait_code(`ROM_CODE_TX, 40, 1'b1);
    cfg[3] = 1'b1;
    pulse(0);
    wait_code(`ROM_CODE_PROTO, 20, 1'b1);
    wait_code(`ROM_CODE_PROTO, PT + 20, 1'b0);
    check({6'h00, 1'(waited >= PT - 10)}, 7'h01);
    cfg[3] = 1'b0;
    wait_code(`ROM_CODE_READY, 20, 1'b1);
  endtask
  task automatic s_standby();
    cmd(`ROM_CMD_STANDBY);
    wait_code(`ROM_CODE_STANDBY, 40, 1'b1);
    hold(50);
    check(code, `ROM_CODE_STANDBY);
    check({6'h00, xo}, 7'h00);
    check({6'h00, supply}, 7'h01);
    cmd(`ROM_CMD_TX);
    hold(10);
    check(code, `ROM_CODE_STANDBY);
    check({3'h0, st}, {3'h0, ROM_STANDBY});
    check(rom_host_model_inst.status_seen[6:0], `ROM_CODE_STANDBY);
    cmd(`ROM_CMD_READY);
    wait_code(`ROM_CODE_READY, 40, 1'b1);
  endtask
  // event-driven exits of transmit and receive, sleep without pending
  task automatic s_events();
    lock_det = 1'b1;
    cfg = 5'h05;
    cmd(`ROM_CMD_RX);
    wait_code(`ROM_CODE_RX, 40, 1'b1);
    pulse(2);
    hold(10);
    check(code, `ROM_CODE_RX);
    cfg[2] = 1'b0;
    pulse(4);
    wait_code(`ROM_CODE_READY, 20, 1'b1);
    cmd(`ROM_CMD_TX);
    wait_code(`ROM_CODE_TX, 40, 1'b1);
    pulse(1);
    wait_code(`ROM_CODE_READY, 20, 1'b1);
    cfg = 5'h08;
    cmd(`ROM_CMD_TX);
    wait_code(`ROM_CODE_TX, 40, 1'b1);
    pulse(1);
    hold(10);
    check(code, `ROM_CODE_TX);
    cmd(`ROM_CMD_ABORT);
    wait_code(`ROM_CODE_PROTO, 20, 1'b1);
    pulse(6);
    wait_code(`ROM_CODE_READY, 10, 1'b1);
    cfg = 5'h00;
    cmd(`ROM_CMD_RX);
    wait_code(`ROM_CODE_RX, 40, 1'b1);
    pulse(3);
    wait_code(`ROM_CODE_READY, 20, 1'b1);
    cmd(`ROM_CMD_SLEEP);
    wait_code(`ROM_CODE_SLEEP, 40, 1'b1);
    pulse(7);
    hold(10);
    check(code, `ROM_CODE_SLEEP);
    cmd(`ROM_CMD_READY);
    wait_code(`ROM_CODE_READY, 40, 1'b1);
  endtask
  // a second power-on reset in mid-run lands in ready again
  task automatic s_rereset();
    cmd(`ROM_CMD_STANDBY);
    wait_code(`ROM_CODE_STANDBY, 40, 1'b1);
    reset_in = 1'b1;
    hold(4);
    reset_in = 1'b0;
    check(code, `ROM_CODE_READY);
    check({3'h0, st}, {3'h0, ROM_READY});
    hold(2);
    check({6'h00, xo}, 7'h01);
    check(code, `ROM_CODE_READY);
  endtask
  task automatic s_shutdown();
    power_off = 1'b1;
    wait_code(`ROM_CODE_OFF, 10, 1'b1);
    check({supply, miso_oe, gpio_oe, 4'h0}, 7'h00);
    // commands sent while off must leave no trace
    cmd(`ROM_CMD_TX);
    check({6'h00, miso_oe}, 7'h00);
    power_off = 1'b0;
    wait_code(`ROM_CODE_READY, SU + 40, 1'b1);
    check({6'h00, 1'(waited >= SU - 5)}, 7'h01);
    hold(LT + 20);
    check(code, `ROM_CODE_READY);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    #1 reset_in = 1'b0;
    s_reset();
    s_lock();
    s_tx();
    s_rx();
    s_standby();
    s_events();
    s_shutdown();
    s_rereset();
    print_verdict();
  end
endmodule
